// *** design/rxpp_defs.vh ***
`ifndef RXPP_DEFS_VH
`define RXPP_DEFS_VH

// register offsets
`define RXPP_REG_RSVD_A     8'h48
`define RXPP_REG_RSVD_B     8'h49
`define RXPP_REG_LINK_CAP   8'h4a
`define RXPP_REG_EMBED      8'h4b
`define RXPP_REG_PAGE_SEL   8'h4c
`define RXPP_REG_PORT_STS   8'h4d

// paged windows
`define RXPP_PAGE_A_LO      8'h4d
`define RXPP_PAGE_A_HI      8'h7f
`define RXPP_PAGE_B_LO      8'hd0
`define RXPP_PAGE_B_HI      8'hdf

// field positions
`define RXPP_CRC_FLAG_BIT   4
`define RXPP_EMB_CNT_HI     7
`define RXPP_EMB_CNT_LO     6
`define RXPP_EMB_TYPE_HI    5
`define RXPP_EMB_TYPE_LO    0
`define RXPP_PHYS_HI        7
`define RXPP_PHYS_LO        6
`define RXPP_RDPORT_HI      5
`define RXPP_RDPORT_LO      4
`define RXPP_STS_PORT_HI    7
`define RXPP_STS_PORT_LO    6

// reset values
`define RXPP_CRC_FLAG_RST   1'b1
`define RXPP_EMB_CNT_RST    2'h0
`define RXPP_EMB_TYPE_RST   6'h12

// access sources: local host plus one per receive port
`define RXPP_SRC_LOCAL      3'h0
`define RXPP_NUM_SRC        5
`define RXPP_NUM_PORT       4

`endif

// *** design/rxpp_port_paging.v ***
`timescale 1ns/10ps
`include "rxpp_defs.vh"

// How it works
// - two-bit read selector picks readback port
// - paging covers 0x4D-0x7F and 0xD0-0xDF
// - per-port write enables allow broadcast writes
// - write enables default 0, carrier port 1
// - read selector defaults 0, or carrier port
// - physical port field: 0 local, else carrier
// - separate page state for every access source
// - count 00 forwards all long packets unchanged
// - count N relabels first N long packets
// - relabelling only in raw input mode
// - six-bit embedded type, reset 0x12, replaces type
// - capability bit 4 gates encoder CRC flag
// - register commands steered by page select
// - status field reports selected read port
module rxpp_port_paging (
  input  wire        clk,         // 100 MHz clock
  input  wire        rst_n,       // async reset, active low
  input  wire        regWr,       // register write command strobe
  input  wire        regRd,       // register read command strobe
  input  wire [7:0]  regAddr,     // register offset
  input  wire [7:0]  regWrData,   // write data
  input  wire [2:0]  regSrc,      // 0 local host, 1..4 channel via port 0..3
  output reg  [7:0]  regRdData,   // read data, valid with regRdValid
  output reg         regRdValid,  // one-cycle read answer
  output reg         pageWrStb,   // write to an external paged register
  output reg  [3:0]  pageWrMask,  // ports that take that write
  output reg         pageRdStb,   // read of an external paged register
  output reg  [1:0]  pageRdPort,  // port that answers that read
  output reg  [7:0]  pageAddr,    // offset of the paged access
  output reg  [7:0]  pageWrData,  // data of the paged write
  input  wire [3:0]  rawMode,     // per port: receiver in raw input mode
  input  wire [3:0]  frameStart,  // per port: frame start pulse
  input  wire [3:0]  longPkt,     // per port: long packet header pulse
  input  wire [23:0] rawTypeIn,   // per port: raw10/raw12 data type, 6 bits each
  output reg  [3:0]  pktOutValid, // per port: outgoing header pulse, one per long packet
  output reg  [23:0] pktTypeOut,  // per port: data type sent, 6 bits each
  output reg  [3:0]  embedFlag,   // per port: header was sent as embedded
  input  wire [3:0]  encCrcErr,   // per port: encoder CRC error pulse
  output reg  [3:0]  encCrcFlag   // per port: gated encoder CRC error pulse
);

  ////////////////////////////////////////////////////////////////////////////
  function [1:0] srcPort;          // carrier port of a source, 0 for local
    input [2:0] src;
    begin
      srcPort = (src == `RXPP_SRC_LOCAL) ? 2'h0 : src[1:0] - 2'h1;
    end
  endfunction

  function isPaged;
    input [7:0] a;
    begin
      isPaged = (a >= `RXPP_PAGE_A_LO && a <= `RXPP_PAGE_A_HI) ||
                (a >= `RXPP_PAGE_B_LO && a <= `RXPP_PAGE_B_HI);
    end
  endfunction

  // reset page state: a channel source starts on its own carrier port
  function [1:0] rstReadPort;
    input integer src;
    begin
      case (src)
        1:       rstReadPort = 2'h0;
        2:       rstReadPort = 2'h1;
        3:       rstReadPort = 2'h2;
        4:       rstReadPort = 2'h3;
        default: rstReadPort = 2'h0;
      endcase
    end
  endfunction

  function [3:0] rstWriteEn;
    input integer src;
    begin
      case (src)
        1:       rstWriteEn = 4'h1;
        2:       rstWriteEn = 4'h2;
        3:       rstWriteEn = 4'h4;
        4:       rstWriteEn = 4'h8;
        default: rstWriteEn = 4'h0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // page state, one copy per source
  reg  [1:0] rdPort_q [0:`RXPP_NUM_SRC-1];
  reg  [3:0] wrEn_q   [0:`RXPP_NUM_SRC-1];
  // sources 5..7 fall back to the local copy
  wire       srcOk   = (regSrc < `RXPP_NUM_SRC);
  wire [2:0] srcIdx  = srcOk ? regSrc : `RXPP_SRC_LOCAL;
  wire [1:0] curRd   = rdPort_q[srcIdx];
  wire [3:0] curWr   = wrEn_q[srcIdx];
  wire [1:0] curPhys = srcPort(srcIdx);

  genvar s;
  generate
    for (s = 0; s < `RXPP_NUM_SRC; s = s + 1) begin : gSrc
      localparam [1:0] RST_RD = rstReadPort(s);
      localparam [3:0] RST_WR = rstWriteEn(s);
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rdPort_q[s] <= RST_RD;
          wrEn_q[s]   <= RST_WR;
        end else if (regWr && srcIdx == s && regAddr == `RXPP_REG_PAGE_SEL) begin
          // bits 7:6 are read-only, only selector and enables take the write
          rdPort_q[s] <= regWrData[`RXPP_RDPORT_HI:`RXPP_RDPORT_LO];
          wrEn_q[s]   <= regWrData[3:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // per-port settings and relabel path
  reg [3:0] crcFlagEn_q;
  reg [1:0] embedCnt_q  [0:`RXPP_NUM_PORT-1];
  reg [5:0] embedType_q [0:`RXPP_NUM_PORT-1];

  genvar p;
  generate
    for (p = 0; p < `RXPP_NUM_PORT; p = p + 1) begin : gPort
      reg  [1:0] pktCnt_q;
      wire [1:0] cntSel = embedCnt_q[p];
      // count is sampled before this header is counted
      wire       relabel = rawMode[p] && (cntSel != 2'h0) && (pktCnt_q < cntSel);
      wire       wrHere  = regWr && curWr[p];   // no enable set leaves the copy alone

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          crcFlagEn_q[p]    <= `RXPP_CRC_FLAG_RST;
          embedCnt_q[p]     <= `RXPP_EMB_CNT_RST;
          embedType_q[p]    <= `RXPP_EMB_TYPE_RST;
        end else if (wrHere) begin
          if (regAddr == `RXPP_REG_LINK_CAP)
            crcFlagEn_q[p]  <= regWrData[`RXPP_CRC_FLAG_BIT];
          if (regAddr == `RXPP_REG_EMBED) begin
            embedCnt_q[p]   <= regWrData[`RXPP_EMB_CNT_HI:`RXPP_EMB_CNT_LO];
            embedType_q[p]  <= regWrData[`RXPP_EMB_TYPE_HI:`RXPP_EMB_TYPE_LO];
          end
        end
      end

      // counts long packets since frame start; saturates at 3
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pktCnt_q <= 2'h0;
        end else if (frameStart[p]) begin
          pktCnt_q <= 2'h0;
        end else if (longPkt[p] && pktCnt_q != 2'h3) begin
          pktCnt_q <= pktCnt_q + 2'h1;
        end
      end

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pktOutValid[p]         <= 1'b0;
          pktTypeOut[6*p +: 6]   <= 6'h00;
          embedFlag[p]           <= 1'b0;
          encCrcFlag[p]          <= 1'b0;
        end else begin
          pktOutValid[p]         <= longPkt[p];
          embedFlag[p]           <= longPkt[p] && relabel;
          if (longPkt[p])         // count 00 or csi-2 mode keeps the raw type
            pktTypeOut[6*p +: 6] <= relabel ? embedType_q[p] : rawTypeIn[6*p +: 6];
          encCrcFlag[p]          <= encCrcErr[p] && crcFlagEn_q[p];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // readback and paged forwarding
  reg [7:0] rdMux;
  always @* begin
    rdMux = 8'h00;        // reserved and unmapped offsets read zero
    case (regAddr)
      `RXPP_REG_LINK_CAP: rdMux = {3'h0, crcFlagEn_q[curRd], 4'h0};
      `RXPP_REG_EMBED:    rdMux = {embedCnt_q[curRd], embedType_q[curRd]};
      `RXPP_REG_PAGE_SEL: rdMux = {curPhys, curRd, curWr};
      default:            rdMux = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
      pageWrStb  <= 1'b0;
      pageWrMask <= 4'h0;
      pageRdStb  <= 1'b0;
      pageRdPort <= 2'h0;
      pageAddr   <= 8'h00;
      pageWrData <= 8'h00;
    end else begin
      regRdValid <= regRd;
      if (regRd) begin
        // only the port number field of the status register lives here
        if (regAddr == `RXPP_REG_PORT_STS)  // port number field of the status register
          regRdData <= {curRd, 6'h00};
        else
          regRdData <= rdMux;
      end
      pageWrStb  <= regWr && isPaged(regAddr);
      pageRdStb  <= regRd && isPaged(regAddr);
      // mask may be zero: the write still completes and nothing updates
      if ((regWr || regRd) && isPaged(regAddr)) begin
        pageWrMask <= regWr ? curWr : 4'h0;
        pageRdPort <= curRd;
        pageAddr   <= regAddr;
        pageWrData <= regWrData;
      end
    end
  end

endmodule // rxpp_port_paging

// *** tb/rxpp_chk_asserts.sv ***
`timescale 1ns/10ps
module rxpp_chk (
  input wire       clk,         // clock
  input wire       rst_n,       // reset
  input wire       regWr,       // write cmd
  input wire       regRd,       // read cmd
  input wire [7:0] regAddr,     // offset
  input wire       regRdValid,  // read answer
  input wire       pageWrStb,   // paged write
  input wire       pageRdStb,   // paged read
  input wire [3:0] rawMode,     // raw input
  input wire [3:0] longPkt,     // header in
  input wire [3:0] pktOutValid, // header out
  input wire [3:0] embedFlag,   // relabelled
  input wire [3:0] encCrcErr,   // crc error
  input wire [3:0] encCrcFlag   // crc flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // status offset left out: it is paged but owned here
  wire pg = (regAddr > 8'h4d && regAddr < 8'h80) || regAddr[7:4] == 4'hd;
  property p_rd_ans; regRd |=> regRdValid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_only; !regRd |=> !regRdValid; endproperty
  a_rd_only: assert property (p_rd_only) else $error("stray read answer");
  property p_pwr; regWr && pg |=> pageWrStb; endproperty
  a_pwr: assert property (p_pwr) else $error("paged write lost");
  property p_shr; (regWr || regRd) && regAddr < 8'h4d |=> !pageWrStb && !pageRdStb; endproperty
  a_shr: assert property (p_shr) else $error("shared offset paged");
  property p_prd; regRd && pg |=> pageRdStb; endproperty
  a_prd: assert property (p_prd) else $error("paged read lost");
  property p_pkt; 1 |=> pktOutValid == $past(longPkt); endproperty
  a_pkt: assert property (p_pkt) else $error("header pulse wrong");
  property p_csi; (longPkt & ~rawMode) != 4'h0 |=> (embedFlag & $past(longPkt & ~rawMode)) == 4'h0; endproperty
  a_csi: assert property (p_csi) else $error("relabel outside raw");
  property p_crc; encCrcErr == 4'h0 |=> encCrcFlag == 4'h0; endproperty
  a_crc: assert property (p_crc) else $error("crc flag uncaused");
  c_rd: cover property (regRd ##1 regRdValid);
  c_emb: cover property (embedFlag != 4'h0);
  c_pwr: cover property (pageWrStb);
endmodule // rxpp_chk

bind rxpp_port_paging rxpp_chk u_chk (.clk(clk), .rst_n(rst_n), .regWr(regWr), .regRd(regRd),
  .regAddr(regAddr), .regRdValid(regRdValid), .pageWrStb(pageWrStb), .pageRdStb(pageRdStb),
  .rawMode(rawMode), .longPkt(longPkt), .pktOutValid(pktOutValid), .embedFlag(embedFlag),
  .encCrcErr(encCrcErr), .encCrcFlag(encCrcFlag));

// *** tb/rxpp_host.sv ***
`timescale 1ns/10ps
module rxpp_host (
  input  wire       clk,       // clock
  output reg        regWr,     // write cmd
  output reg        regRd,     // read cmd
  output reg  [7:0] regAddr,   // offset
  output reg  [7:0] regWrData, // data
  output reg  [2:0] regSrc,    // source
  input  wire [7:0] regRdData  // read data
);
  initial {regWr, regRd, regAddr, regWrData, regSrc} = 21'h0;
  task wr(input [2:0] s, input [7:0] a, input [7:0] d);
    @(negedge clk) {regWr, regSrc, regAddr, regWrData} = {1'b1, s, a, d};
    @(negedge clk) regWr = 1'b0;
  endtask
  // answer lands one edge after the command
  task rd(input [2:0] s, input [7:0] a, output [7:0] d);
    @(negedge clk) {regRd, regSrc, regAddr} = {1'b1, s, a};
    @(negedge clk) regRd = 1'b0;
    d = regRdData;
  endtask
endmodule // rxpp_host

// *** tb/tb_rxpp_port_paging.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("unexpected %0t got %h want %h", $time, g, e); end end
module tb_rxpp_port_paging;
  reg         clk = 0, rst_n = 0;
  reg  [3:0]  rawMode = 4'h0, frameStart = 4'h0, longPkt = 4'h0, encCrcErr = 4'h0;
  reg  [23:0] rawTypeIn = {4{6'h2b}};
  wire        regWr, regRd;
  wire [7:0]  regAddr, regWrData, regRdData, pageAddr, pageWrData;
  wire        regRdValid, pageWrStb, pageRdStb;
  wire [3:0]  pageWrMask, pktOutValid;
  wire [1:0]  pageRdPort;
  wire [2:0]  regSrc;
  wire [23:0] pktTypeOut;
  wire [3:0]  embedFlag, encCrcFlag;
  integer     failures = 0, cmp_count = 0, cyc = 0, i, n;
  reg  [7:0]  d;
  rxpp_host u_host (.clk(clk), .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData),
    .regSrc(regSrc), .regRdData(regRdData));
  rxpp_port_paging u_dut (.clk(clk), .rst_n(rst_n), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWrData(regWrData), .regSrc(regSrc), .regRdData(regRdData), .regRdValid(regRdValid),
    .pageWrStb(pageWrStb), .pageWrMask(pageWrMask), .pageRdStb(pageRdStb), .pageRdPort(pageRdPort),
    .pageAddr(pageAddr), .pageWrData(pageWrData), .rawMode(rawMode),
    .frameStart(frameStart), .longPkt(longPkt), .rawTypeIn(rawTypeIn), .pktOutValid(pktOutValid),
    .pktTypeOut(pktTypeOut), .embedFlag(embedFlag), .encCrcErr(encCrcErr), .encCrcFlag(encCrcFlag));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin failures++; wrap_up; end
  end
  task wrap_up;
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task rdc(input [2:0] s, input [7:0] a, input [7:0] e);
    u_host.rd(s, a, d);
    `CHK(d, e)
    `CHK(regRdValid, 1'b1)
  endtask
  task fs;
    @(negedge clk) frameStart = 4'h1;
    @(negedge clk) frameStart = 4'h0;
  endtask
  task pk(input [3:0] ef, input [5:0] et);
    @(negedge clk) longPkt = 4'h1;
    @(negedge clk) longPkt = 4'h0;
    `CHK(pktOutValid, 4'h1)
    `CHK(embedFlag, ef)
    `CHK(pktTypeOut[5:0], et)
  endtask
  task crc(input [3:0] e);
    @(negedge clk) encCrcErr = 4'h1;
    @(negedge clk) encCrcErr = 4'h0;
    `CHK(encCrcFlag, e)
  endtask
  initial begin
    #20 rst_n = 1;
    rdc(0, 8'h4c, 8'h00);
    rdc(3, 8'h4c, 8'ha4);
    rdc(0, 8'h4a, 8'h10);
    rdc(0, 8'h4b, 8'h12);
    rdc(0, 8'h48, 8'h00);
    u_host.wr(0, 8'h4c, 8'h35);
    rdc(0, 8'h4c, 8'h35);
    u_host.wr(2, 8'h4c, 8'h3f);
    rdc(2, 8'h4c, 8'h7f);
    rdc(0, 8'h4c, 8'h35);
    rdc(5, 8'h4c, 8'h35);
    rdc(4, 8'h4c, 8'hf8);
    rdc(1, 8'h4c, 8'h01);
    rdc(0, 8'h4d, 8'hc0);
    u_host.wr(0, 8'h4b, 8'h52);
    for (i = 0; i < 4; i++) begin
      u_host.wr(0, 8'h4c, {2'b00, i[1:0], 4'h5});
      rdc(0, 8'h4b, i % 2 ? 8'h12 : 8'h52);
    end
    u_host.wr(0, 8'h4c, 8'h00);
    u_host.wr(0, 8'h4b, 8'h00);
    rdc(0, 8'h4b, 8'h52);
    u_host.wr(0, 8'h60, 8'haa);
    `CHK({pageWrStb, pageWrMask, pageAddr, pageWrData}, {1'b1, 4'h0, 8'h60, 8'haa})
    u_host.wr(0, 8'h4c, 8'h2a);
    `CHK(pageWrStb, 1'b0)
    u_host.wr(0, 8'hd0, 8'h55);
    `CHK({pageWrStb, pageWrMask, pageAddr, pageWrData}, {1'b1, 4'ha, 8'hd0, 8'h55})
    rdc(0, 8'hd5, 8'h00);
    `CHK({pageRdStb, pageRdPort, pageAddr}, {1'b1, 2'h2, 8'hd5})
    u_host.wr(0, 8'h4c, 8'h01);
    rawMode = 4'h1;
    for (n = 0; n < 4; n++) begin
      u_host.wr(0, 8'h4b, {n[1:0], 6'h21});
      fs;
      for (i = 0; i < 4; i++) pk(i < n, i < n ? 6'h21 : 6'h2b);
    end
    rawMode = 4'h0;
    fs;
    pk(4'h0, 6'h2b);
    crc(4'h1);
    u_host.wr(0, 8'h4a, 8'h00);
    crc(4'h0);
    rdc(0, 8'h4a, 8'h00);
    wrap_up;
  end
endmodule // tb_rxpp_port_paging
